// [common/ceq_pkg.sv]
`default_nettype none
package ceq_pkg;
   // ****************************************************************
   // clock and timebase
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int SHORT_PULSE_US = 416;
   localparam int SHORT_PULSE_CYCLES = (SHORT_PULSE_US * 1000) / CLK_PERIOD_NS;
   localparam int TICK_W = 14;
   localparam int PULSE_W = 13;

   // ****************************************************************
   // tone timing in milliseconds
   // ****************************************************************
   localparam logic [7:0] TONE_MAX_MS = 8'h55;       // 85 ms longest tone
   localparam logic [7:0] GUARD_REF_MS = 8'h42;      // 66 ms guard reference
   localparam logic [7:0] SETTLE_MS = 8'h19;         // 25 ms delay
   localparam logic [10:0] CLUSTER_MS = 11'h7d0;     // 2000 ms window
   localparam logic [7:0] DET_AFTER_MS = 8'h0a;      // 10 ms, within 15
   localparam logic [7:0] DET_MIN_START_MS = 8'h3c;  // 60 ms from start
   localparam logic [7:0] MS_SAT = 8'hff;

   // ****************************************************************
   // register map (word offsets on the bus)
   // ****************************************************************
   localparam logic [1:0] IDX_CTRL = 2'h0;
   localparam logic [1:0] IDX_LIMIT = 2'h1;
   localparam logic [1:0] IDX_STATUS = 2'h2;
   localparam int ADDR_LO = 2;
   localparam int ADDR_HI = 3;
   // ctrl fields
   localparam int C_EN = 0;
   localparam int C_MEI = 1;
   localparam int C_GONLY = 2;
   localparam int C_DUR = 3;
   localparam int C_MUTE = 4;
   localparam int C_CLU = 5;
   localparam int C_GP_LO = 8;
   localparam int C_GP_HI = 15;
   // limit fields
   localparam int L_LOW_LO = 0;
   localparam int L_LOW_HI = 7;
   localparam int L_MUTE_LO = 8;
   localparam int L_MUTE_HI = 15;
   // status fields, low four are sticky and write-one-to-clear
   localparam int S_EDGE = 0;
   localparam int S_TOUT = 1;
   localparam int S_REJ = 2;
   localparam int S_DONE = 3;
   localparam int S_LEVEL = 4;
   localparam int S_BUSY = 5;
   localparam logic [7:0] CTRL_RST_GP = 8'h42;
   localparam logic [7:0] LIM_LOW_RST = 8'h50;
   localparam logic [7:0] LIM_MUTE_RST = 8'h05;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : ceq_pkg
`default_nettype wire

// [common/ceq_link_if.sv]
`default_nettype none
interface ceq_link_if;
   logic detect_n; // active-low detector output pin
   modport detector (output detect_n);
   modport ctrl (input detect_n);
endinterface : ceq_link_if
`default_nettype wire

// [hdl/ceq_detector.sv]
`default_nettype none
// ********************************************************************
// tone detector end: short-pulse or guard-timed output
// ********************************************************************
module ceq_detector #(
   parameter int MS_CYCLES = ceq_pkg::MS_CYCLES,
   parameter int PULSE_CYCLES = ceq_pkg::SHORT_PULSE_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   ceq_link_if.detector lnk,
   input wire logic tone_present,
   input wire logic short_variant,
   input wire logic [7:0] guard_present_time,
   input wire logic [7:0] guard_absent_time
);
   typedef enum {D_IDLE, D_TONE, D_WAIT, D_PULSE} ceq_dst_t;
   typedef struct packed {
      logic s1;
      logic s2;
      logic [ceq_pkg::TICK_W-1:0] tick_cnt;
      ceq_dst_t st;
      logic [7:0] start_ms;
      logic [7:0] end_ms;
      logic [ceq_pkg::PULSE_W-1:0] pulse_cnt;
      logic [7:0] gp_ms;
      logic [7:0] ga_ms;
      logic guard_low;
   } ceq_dstate_t;

   ceq_dstate_t q;
   ceq_dstate_t d;
   logic tick;

   assign tick = (q.tick_cnt == ceq_pkg::TICK_W'(MS_CYCLES - 1));

   // next state of both variants
   always_comb begin
      d = q;
      d.s1 = tone_present;
      d.s2 = q.s1;
      d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
      if (tick && q.start_ms != ceq_pkg::MS_SAT) begin
         d.start_ms = q.start_ms + 1'b1;
      end
      case (q.st)
         D_IDLE: begin
            d.start_ms = '0;
            if (short_variant && q.s2) begin
               d.st = D_TONE;
            end
         end
         D_TONE: begin
            d.end_ms = '0;
            if (!q.s2) begin
               d.st = D_WAIT;
            end
         end
         D_WAIT: begin
            if (tick) begin
               d.end_ms = q.end_ms + 1'b1;
            end
            // pulse a fixed delay after tone end, once start_ms has counted 60 free-running ms ticks (can be just under 60 ms)
            if (q.end_ms >= ceq_pkg::DET_AFTER_MS &&
                q.start_ms >= ceq_pkg::DET_MIN_START_MS) begin
               d.st = D_PULSE;
               d.pulse_cnt = '0;
            end
         end
         D_PULSE: begin
            d.pulse_cnt = q.pulse_cnt + 1'b1;
            if (q.pulse_cnt == ceq_pkg::PULSE_W'(PULSE_CYCLES - 1)) begin
               d.st = D_IDLE;
            end
         end
         default: d.st = D_IDLE;
      endcase
      // guard-timed output: low after present for gp, high after absent for ga
      if (q.s2) begin
         d.ga_ms = '0;
         if (tick && q.gp_ms != ceq_pkg::MS_SAT) begin
            d.gp_ms = q.gp_ms + 1'b1;
         end
         if (q.gp_ms >= guard_present_time) begin
            d.guard_low = 1'b1;
         end
      end else begin
         d.gp_ms = '0;
         if (tick && q.ga_ms != ceq_pkg::MS_SAT) begin
            d.ga_ms = q.ga_ms + 1'b1;
         end
         if (q.ga_ms >= guard_absent_time) begin
            d.guard_low = 1'b0;
         end
      end
      if (short_variant) begin
         d.guard_low = 1'b0;
      end
   end

   // one register bank, frozen while ce is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{st: D_IDLE, default: '0};
      end else if (ce) begin
         q <= d;
      end
   end

   // pin low during the short pulse or while the guard-timed output is low
   assign lnk.detect_n = !((q.st == D_PULSE) || q.guard_low);
endmodule : ceq_detector
`default_nettype wire

// [hdl/ceq_qualifier.sv]
`default_nettype none
// ********************************************************************
// end-of-tone qualifier with ahb-lite register slave
// ********************************************************************
// Overview of operation
// - falling detect edge starts qualification
// - end of tone: rising edge or timeout
// - guard-present time sixty-six milliseconds
// - timeout nineteen ms when guard is 66
// - short pulse returns high after 416 us
// - start 25 ms delay at end of tone
// - on expiry: on-hook or parallel check
// - sample detector throughout the timeout
// - on-hook within 60 ms of tone end
// - guard-only short guard lengthens delay
// - detector level readable by software
// - reject detections with too-long low pulse
// - mute check rejects early return high
// - strap bypasses mute check
// - short pulse within 15 ms after tone
// - speech may delay pulse to 35 ms
// - pulse not before 60 ms from start; detector counts 60 free-running ms ticks, so can pulse just under 60 ms
// - tones last at most 85 ms
// - 2 s cluster window ignores detections
module ceq_qualifier #(
   parameter int MS_CYCLES = ceq_pkg::MS_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   ceq_link_if.ctrl lnk,
   input wire logic mute_check_skip,
   output logic mic_mute,
   output logic on_hook_req,
   output logic parallel_check_req
);
   typedef enum {Q_IDLE, Q_EOT, Q_DELAY} ceq_qst_t;
   typedef struct packed {
      logic det1;
      logic det2;
      logic det_prev;
      logic strap1;
      logic strap2;
      logic [ceq_pkg::TICK_W-1:0] tick_cnt;
      ceq_qst_t st;
      logic [7:0] ms_cnt;
      logic [7:0] delay_ms;
      logic clu_act;
      logic [10:0] clu_cnt;
      logic [15:0] ctrl;
      logic [15:0] limit;
      logic [3:0] sts;
      logic a_wr;
      logic a_rd;
      logic [1:0] a_idx;
      logic [31:0] rdata;
      logic mute;
      logic on_hook;
      logic par_chk;
   } ceq_qstate_t;

   ceq_qstate_t q;
   ceq_qstate_t d;
   logic tick;
   logic fall;
   logic rise;
   logic take;
   logic [7:0] gp;
   logic [7:0] tout_ms;
   logic [7:0] settle_ms;
   logic [3:0] sts_set;
   logic [31:0] status_word;
   logic mute_on;

   // ****************************************************************
   // timebase and edges
   // ****************************************************************
   assign tick = (q.tick_cnt == ceq_pkg::TICK_W'(MS_CYCLES - 1));
   assign fall = q.det_prev && !q.det2;
   assign rise = !q.det_prev && q.det2;
   assign gp = q.ctrl[ceq_pkg::C_GP_HI:ceq_pkg::C_GP_LO];
   // tones are bounded, so 85 - gp after detection the tone is over
   assign tout_ms = (gp < ceq_pkg::TONE_MAX_MS) ?
                    ceq_pkg::TONE_MAX_MS - gp : '0;
   // guard-only builds with a short guard need a longer settle time
   assign settle_ms = (q.ctrl[ceq_pkg::C_GONLY] && gp < ceq_pkg::GUARD_REF_MS) ?
                      ceq_pkg::SETTLE_MS + (ceq_pkg::GUARD_REF_MS - gp) :
                      ceq_pkg::SETTLE_MS;
   assign mute_on = q.ctrl[ceq_pkg::C_MUTE] && !q.strap2;
   assign take = hsel && hready &&
                 (htrans == ceq_pkg::HTRANS_NONSEQ || htrans == ceq_pkg::HTRANS_SEQ);
   assign status_word = {26'h0, (q.st != Q_IDLE), q.det2, q.sts};

   // ****************************************************************
   // qualifier and bus next state
   // ****************************************************************
   always_comb begin
      d = q;
      sts_set = '0;
      d.det1 = lnk.detect_n;
      d.det2 = q.det1;
      d.det_prev = q.det2;
      d.strap1 = mute_check_skip;
      d.strap2 = q.strap1;
      d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
      d.on_hook = 1'b0;
      d.par_chk = 1'b0;
      // cluster window, restarted by any edge while open
      if (q.clu_act && tick) begin
         d.clu_cnt = q.clu_cnt + 1'b1;
         if (q.clu_cnt == ceq_pkg::CLUSTER_MS - 1'b1) begin
            d.clu_act = 1'b0;
         end
      end
      if (q.ctrl[ceq_pkg::C_CLU] && (fall || rise)) begin
         d.clu_act = 1'b1;
         d.clu_cnt = '0;
      end
      if (!q.ctrl[ceq_pkg::C_CLU]) begin
         d.clu_act = 1'b0;
      end
      case (q.st)
         Q_IDLE: begin
            d.ms_cnt = '0;
            d.mute = 1'b0;
            if (q.ctrl[ceq_pkg::C_EN] && fall && !q.clu_act) begin
               d.st = Q_EOT;
               d.mute = mute_on;
            end
         end
         Q_EOT: begin
            if (tick) begin
               d.ms_cnt = q.ms_cnt + 1'b1;
            end
            if (rise) begin
               d.mute = 1'b0;
               if (q.ctrl[ceq_pkg::C_DUR] &&
                   q.ms_cnt > q.limit[ceq_pkg::L_LOW_HI:ceq_pkg::L_LOW_LO]) begin
                  sts_set[ceq_pkg::S_REJ] = 1'b1;
                  d.st = Q_IDLE;
               end else if (mute_on &&
                   q.ms_cnt < q.limit[ceq_pkg::L_MUTE_HI:ceq_pkg::L_MUTE_LO]) begin
                  sts_set[ceq_pkg::S_REJ] = 1'b1;
                  d.st = Q_IDLE;
               end else begin
                  sts_set[ceq_pkg::S_EDGE] = 1'b1;
                  d.st = Q_DELAY;
                  d.delay_ms = '0;
               end
            end else if (q.ms_cnt >= tout_ms) begin
               d.mute = 1'b0;
               if (q.ctrl[ceq_pkg::C_DUR]) begin
                  sts_set[ceq_pkg::S_REJ] = 1'b1;
                  d.st = Q_IDLE;
               end else begin
                  sts_set[ceq_pkg::S_TOUT] = 1'b1;
                  d.st = Q_DELAY;
                  d.delay_ms = '0;
               end
            end
         end
         Q_DELAY: begin
            if (tick) begin
               d.delay_ms = q.delay_ms + 1'b1;
            end
            // ticks are free-running, so wait one past the count: never short of a full delay
            if (q.delay_ms > settle_ms) begin
               d.on_hook = q.ctrl[ceq_pkg::C_MEI];
               d.par_chk = !q.ctrl[ceq_pkg::C_MEI];
               sts_set[ceq_pkg::S_DONE] = 1'b1;
               d.st = Q_IDLE;
            end
         end
         default: d.st = Q_IDLE;
      endcase
      if (!q.ctrl[ceq_pkg::C_EN]) begin
         d.st = Q_IDLE;
         d.mute = 1'b0;
      end
      // bus data phase: writes land here, status clears one bit per one
      if (q.a_wr) begin
         case (q.a_idx)
            ceq_pkg::IDX_CTRL: d.ctrl = hwdata[15:0];
            ceq_pkg::IDX_LIMIT: d.limit = hwdata[15:0];
            ceq_pkg::IDX_STATUS: d.sts = q.sts & ~hwdata[3:0];
            default: d.sts = q.sts;
         endcase
      end
      // hardware set wins over a clear in the same cycle
      d.sts = d.sts | sts_set;
      // bus address phase: capture and prepare read data
      d.a_wr = take && hwrite;
      d.a_rd = take && !hwrite;
      d.a_idx = haddr[ceq_pkg::ADDR_HI:ceq_pkg::ADDR_LO];
      if (take && !hwrite) begin
         case (haddr[ceq_pkg::ADDR_HI:ceq_pkg::ADDR_LO])
            ceq_pkg::IDX_CTRL: d.rdata = {16'h0, q.ctrl};
            ceq_pkg::IDX_LIMIT: d.rdata = {16'h0, q.limit};
            ceq_pkg::IDX_STATUS: d.rdata = status_word;
            default: d.rdata = '0;
         endcase
      end
   end

   // one register bank, frozen while ce is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{st: Q_IDLE, det1: 1'b1, det2: 1'b1, det_prev: 1'b1,
                ctrl: {ceq_pkg::CTRL_RST_GP, 8'h00},
                limit: {ceq_pkg::LIM_MUTE_RST, ceq_pkg::LIM_LOW_RST},
                default: '0};
      end else if (ce) begin
         q <= d;
      end
   end

   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign mic_mute = q.mute;
   assign on_hook_req = q.on_hook;
   assign parallel_check_req = q.par_chk;
endmodule : ceq_qualifier
`default_nettype wire

// [sim/ceq_link_monitor.sv]
`default_nettype none
// ********************************************************************
// link monitor: detector pin timing and controller actions
// ********************************************************************
module ceq_link_monitor #(
   parameter int MS_CYCLES = 20,
   parameter int PULSE_CYCLES = 5
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic detect_n,
   input wire logic tone_present,
   input wire logic short_variant,
   input wire logic mic_mute,
   input wire logic on_hook_req,
   input wire logic parallel_check_req
);
   logic det_q;
   logic tone_q;
   logic [15:0] fall_cnt_q;
   logic [15:0] end_cnt_q;
   logic [15:0] start_cnt_q;
   logic act;

   function automatic logic [15:0] sat(input logic [15:0] v);
      return (v == 16'hffff) ? v : v + 16'h1;
   endfunction : sat

   // either action request
   assign act = on_hook_req | parallel_check_req;

   // ages of last pin fall, tone end and tone start; saturate so idle stays old
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         det_q <= 1'b1;
         tone_q <= 1'b0;
         fall_cnt_q <= 16'hffff;
         end_cnt_q <= 16'hffff;
         start_cnt_q <= 16'h0;
      end else begin
         det_q <= detect_n;
         tone_q <= tone_present;
         fall_cnt_q <= (det_q && !detect_n) ? 16'h0 : sat(fall_cnt_q);
         end_cnt_q <= tone_present ? 16'h0 : sat(end_cnt_q);
         start_cnt_q <= (tone_present && !tone_q) ? 16'h0 : sat(start_cnt_q);
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_pulse_width;
      $rose(detect_n) && short_variant |-> fall_cnt_q == 16'(PULSE_CYCLES - 1);
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("short pulse width");
   property p_after_tone;
      $fell(detect_n) && short_variant |-> end_cnt_q <= 16'(15 * MS_CYCLES);
   endproperty
   a_after_tone: assert property (p_after_tone) else $error("pulse late");
   property p_after_start;
      $fell(detect_n) && short_variant |-> start_cnt_q >= 16'(60 * MS_CYCLES);
   endproperty
   a_after_start: assert property (p_after_start) else $error("pulse early");
   property p_settle;
      act |-> fall_cnt_q >= 16'(25 * MS_CYCLES);
   endproperty
   a_settle: assert property (p_settle) else $error("action before delay");
   property p_onhook_60;
      on_hook_req |-> end_cnt_q <= 16'(60 * MS_CYCLES);
   endproperty
   a_onhook_60: assert property (p_onhook_60) else $error("on-hook too late");
   property p_req_excl;
      !(on_hook_req && parallel_check_req);
   endproperty
   a_req_excl: assert property (p_req_excl) else $error("both requests");
   property p_req_pulse;
      act |=> !act;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request too long");
   property p_mute_prompt;
      $rose(mic_mute) |-> fall_cnt_q <= 16'h8;
   endproperty
   a_mute_prompt: assert property (p_mute_prompt) else $error("mute late");
endmodule : ceq_link_monitor
`default_nettype wire

// [sim/cas_end_of_tone_qualifier_tb.sv]
`default_nettype none
// ********************************************************************
// bench: detector and qualifier joined by the link
// ********************************************************************
module cas_end_of_tone_qualifier_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MS = 20;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic mute_check_skip = 1'b0;
   logic mic_mute;
   logic on_hook_req;
   logic parallel_check_req;
   logic tone_present = 1'b0;
   logic short_variant = 1'b1;
   logic [7:0] guard_present_time = 8'h42;
   logic [7:0] guard_absent_time = 8'h02;
   int checks = 0;
   int mismatches = 0;
   int cyc = 0;
   int nreq = 0;
   int t_fall = 0;
   int t_req = 0;
   logic [1:0] kind = 2'h0;
   logic det_q = 1'b1;
   logic mute_seen = 1'b0;
   logic [31:0] rd;

   ceq_link_if lnk();
   ceq_detector #(.MS_CYCLES(MS), .PULSE_CYCLES(5)) u_ceq_detector (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .lnk(lnk.detector),
      .tone_present(tone_present), .short_variant(short_variant),
      .guard_present_time(guard_present_time), .guard_absent_time(guard_absent_time));
   ceq_qualifier #(.MS_CYCLES(MS)) u_ceq_qualifier (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lnk(lnk.ctrl),
      .mute_check_skip(mute_check_skip), .mic_mute(mic_mute), .on_hook_req(on_hook_req),
      .parallel_check_req(parallel_check_req));
   ceq_link_monitor #(.MS_CYCLES(MS), .PULSE_CYCLES(5)) u_ceq_link_monitor (
      .hclk(hclk), .hresetn(hresetn), .detect_n(lnk.detect_n), .tone_present(tone_present),
      .short_variant(short_variant), .mic_mute(mic_mute), .on_hook_req(on_hook_req),
      .parallel_check_req(parallel_check_req));

   // single slave, so its ready is the bus ready
   assign hready = hreadyout;
   always #50 hclk = ~hclk;

   // timestamps of pin falls and action pulses
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      det_q <= lnk.detect_n;
      if (det_q === 1'b1 && lnk.detect_n === 1'b0) t_fall <= cyc;
      if (mic_mute === 1'b1) mute_seen <= 1'b1;
      if (on_hook_req === 1'b1 || parallel_check_req === 1'b1) begin
         t_req <= cyc;
         kind <= {on_hook_req, parallel_check_req};
         nreq <= nreq + 1;
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one single transfer; waits on hready with no assumed latency
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= ceq_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask : ahb

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask : rdchk

   // one tone, then action kind, latency from pin fall (ms window) and sticky status
   task automatic scen(input logic [15:0] ctl, input logic sv, input logic [7:0] gp,
         input logic [7:0] ga, input int tone, input int lo, input int hi,
         input logic [1:0] want, input logic [3:0] st, input logic [3:0] msk);
      int n0;
      int lat;
      ahb(1'b1, 32'h0, {16'h0, ctl}, rd);
      short_variant <= sv;
      guard_present_time <= gp;
      guard_absent_time <= ga;
      n0 = nreq;
      tone_present <= 1'b1;
      repeat (tone * MS) @(posedge hclk);
      tone_present <= 1'b0;
      repeat (150 * MS) @(posedge hclk);
      lat = t_req - t_fall;
      chk(32'(nreq - n0), {31'h0, want != 2'h0});
      if (want != 2'h0) begin
         chk({30'h0, kind}, {30'h0, want});
         chk({31'h0, lat >= lo * MS && lat <= hi * MS}, 32'h1);
      end
      ahb(1'b0, 32'h8, 32'h0, rd);
      // settled by now: pin level high, not busy, sticky bits as asked
      chk(rd & {28'hfffffff, msk}, {26'h0, 2'b01, st & msk});
      ahb(1'b1, 32'h8, 32'hf, rd);
   endtask : scen

   // cut a hang short
   initial begin
      repeat (70000) @(posedge hclk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(32'h0, 32'h00004200);
      rdchk(32'h4, 32'h00000550);
      rdchk(32'h8, 32'h00000010);
      ahb(1'b1, 32'hc, 32'hffffffff, rd);
      rdchk(32'hc, 32'h0);
      ahb(1'b1, 32'h4, 32'h0000050a, rd);
      rdchk(32'h4, 32'h0000050a);
      scen(16'h4203, 1'b1, 8'h42, 8'h02, 75, 25, 27, 2'h2, 4'h9, 4'hf);
      scen(16'h4201, 1'b0, 8'h42, 8'h02, 75, 34, 38, 2'h1, 4'h9, 4'hf);
      scen(16'h4203, 1'b0, 8'h42, 8'h28, 75, 43, 46, 2'h2, 4'ha, 4'hf);
      scen(16'h2805, 1'b0, 8'h28, 8'h02, 75, 86, 90, 2'h1, 4'h9, 4'hf);
      scen(16'h420b, 1'b0, 8'h42, 8'h02, 85, 0, 0, 2'h0, 4'h4, 4'h4);
      scen(16'h420b, 1'b1, 8'h42, 8'h02, 85, 25, 27, 2'h2, 4'h9, 4'hf);
      scen(16'h4213, 1'b1, 8'h42, 8'h02, 75, 0, 0, 2'h0, 4'h4, 4'h4);
      chk({31'h0, mute_seen}, 32'h1);
      mute_check_skip <= 1'b1;
      scen(16'h4213, 1'b1, 8'h42, 8'h02, 75, 25, 27, 2'h2, 4'h9, 4'hf);
      scen(16'h4223, 1'b1, 8'h42, 8'h02, 75, 25, 27, 2'h2, 4'h9, 4'hf);
      scen(16'h4223, 1'b1, 8'h42, 8'h02, 75, 0, 0, 2'h0, 4'h0, 4'h8);
      tally_and_finish();
   end
endmodule : cas_end_of_tone_qualifier_tb
`default_nettype wire
